// File: hdl/rsd_pkg.sv
// constants, opcodes and carriers for the rotate and subtract datapath
// assumes an 8-bit core; no timing constants are needed
package rsd_pkg;
    localparam int DATA_W = 8;
    localparam int MSB = 7;
    localparam int LSB = 0;
    localparam int NIB_MSB = 3;
    localparam logic [7:0] WREG_RESET = 8'h00;
    localparam logic FLAG_RESET = 1'b0;

    // operation codes presented by the instruction decoder
    typedef enum logic [2:0] {
        OP_NONE = 3'h0,
        OP_ROT_L_CY_WREG = 3'h1,
        OP_ROT_R_MEM = 3'h2,
        OP_ROT_R_WREG = 3'h3,
        OP_ROT_R_CY_MEM = 3'h4,
        OP_ROT_R_CY_WREG = 3'h5,
        OP_SUB_BORROW = 3'h6
    } op_e;

    // status flags of the core
    typedef struct packed {
        logic twos_compl_range_flag;
        logic zero;
        logic half_borrow_flag;
        logic carry;
    } flags_s;

    // one memory write request
    typedef struct packed {
        logic wr;
        logic [7:0] data;
    } mem_wr_s;
endpackage

// File: hdl/rsd_subtractor.sv
// subtract-with-borrow arithmetic unit, purely combinational
// assumes operands are stable for the cycle the result is sampled
`timescale 1ns/1ps
`default_nettype none
module rsd_subtractor
    import rsd_pkg::*;
#(
    parameter int WIDTH = DATA_W
) (
    input wire logic [WIDTH-1:0] minuend_in,
    input wire logic [WIDTH-1:0] subtrahend_in,
    input wire logic carry_in,
    output logic [WIDTH-1:0] diff_out,
    output flags_s flags_out
);
    logic borrow_in;
    logic [WIDTH:0] full;
    logic [NIB_MSB+1:0] low;
    logic no_borrow;
    logic no_half_borrow;
    logic is_zero;
    logic range_err;

    // borrow is the complement of carry; extra bit catches the final borrow
    assign borrow_in = ~carry_in;
    assign full = {1'b0, minuend_in} - {1'b0, subtrahend_in} - {{WIDTH{1'b0}}, borrow_in};
    assign low = {1'b0, minuend_in[NIB_MSB:0]} - {1'b0, subtrahend_in[NIB_MSB:0]}
        - {{(NIB_MSB+1){1'b0}}, borrow_in};
    assign diff_out = full[WIDTH-1:0];

    // carry set means no borrow, i.e. result zero or positive
    assign no_borrow = ~full[WIDTH];
    assign no_half_borrow = ~low[NIB_MSB+1];
    assign is_zero = (full[WIDTH-1:0] == '0);
    // signed overflow: operand signs differ and result sign differs from minuend
    assign range_err = (minuend_in[WIDTH-1] ^ subtrahend_in[WIDTH-1])
        & (minuend_in[WIDTH-1] ^ full[WIDTH-1]);
    // one driver for the whole flag bundle
    assign flags_out = '{range_err, is_zero, no_half_borrow, no_borrow};
endmodule
`default_nettype wire

// File: hdl/rotate_and_subtract_datapath.sv
// rotate and subtract-with-borrow datapath with working register and flags
// assumes the decoder gives one op per cycle with the memory byte already read
// Overview of operation
// - rotate left through carry puts byte<<1 with old carry at bit 0 in wreg, bit 7 to carry.
// - rotate right memory writes the byte rotated right, bit 0 into bit 7, flags kept.
// - rotate right to wreg loads the right-rotated byte into wreg, memory and flags kept.
// - rotate right through carry writes byte>>1 with old carry at bit 7, bit 0 to carry.
// - rotate right through carry to wreg loads that value into wreg, bit 0 to carry.
// - subtract with borrow loads wreg minus byte minus inverted carry into wreg.
// - after subtraction carry is 0 if negative else 1, and range, zero, half flags update.
`timescale 1ns/1ps
`default_nettype none
module rotate_and_subtract_datapath
    import rsd_pkg::*;
#(
    parameter int WIDTH = DATA_W
) (
    input wire logic ref_clk_in,
    input wire logic rst_n_in,
    input wire op_e op_in,
    input wire logic [WIDTH-1:0] mem_rdata_in,
    output logic [WIDTH-1:0] working_reg_out,
    output flags_s flags_out,
    output mem_wr_s mem_wr_out
);
    // one place per rotate; the top bit index follows the width parameter
    localparam int STEP = 1;
    localparam int TOP = WIDTH - 1;

    // architectural state: working register and the four status flags
    logic [WIDTH-1:0] working_reg;
    logic carry;
    logic zero;
    logic half_borrow_flag;
    logic twos_compl_range_flag;

    // memory write-back port, a strobe flop and a WIDTH-bit data register, so the strobe can drop on its own
    logic mem_wr_strobe;
    logic [WIDTH-1:0] mem_wr_data;

    // decoded instruction strobes, at most one high per cycle
    logic dec_rot_l_cy_wreg;
    logic dec_rot_r_mem;
    logic dec_rot_r_wreg;
    logic dec_rot_r_cy_mem;
    logic dec_rot_r_cy_wreg;
    logic dec_sub_borrow;

    // grouped strobes: who loads carry, and which ops write memory
    logic carry_from_msb;
    logic carry_from_lsb;
    logic writes_mem;

    // results offered by the rotate network and the subtractor;
    // every one of them is built each cycle whether used or not
    logic [WIDTH-1:0] rot_r;
    logic [WIDTH-1:0] rot_r_cy;
    logic [WIDTH-1:0] rot_l_cy;
    logic [WIDTH-1:0] sub_diff;
    flags_s sub_flags;
    logic [WIDTH-1:0] mem_result;

    // instruction decode; the spare code falls to the default branch and
    // behaves as an idle cycle, so a corrupt opcode moves no state at all
    // a one-hot decode keeps each destination mux a plain and-or
    always_comb begin
        dec_rot_l_cy_wreg = 1'b0;
        dec_rot_r_mem = 1'b0;
        dec_rot_r_wreg = 1'b0;
        dec_rot_r_cy_mem = 1'b0;
        dec_rot_r_cy_wreg = 1'b0;
        dec_sub_borrow = 1'b0;
        case (op_in)
            OP_ROT_L_CY_WREG: begin
                dec_rot_l_cy_wreg = 1'b1;
            end
            OP_ROT_R_MEM: begin
                dec_rot_r_mem = 1'b1;
            end
            OP_ROT_R_WREG: begin
                dec_rot_r_wreg = 1'b1;
            end
            OP_ROT_R_CY_MEM: begin
                dec_rot_r_cy_mem = 1'b1;
            end
            OP_ROT_R_CY_WREG: begin
                dec_rot_r_cy_wreg = 1'b1;
            end
            OP_SUB_BORROW: begin
                dec_sub_borrow = 1'b1;
            end
            default: begin
                dec_sub_borrow = 1'b0;
            end
        endcase
    end

    assign carry_from_msb = dec_rot_l_cy_wreg;
    assign carry_from_lsb = dec_rot_r_cy_mem | dec_rot_r_cy_wreg;
    assign writes_mem = dec_rot_r_mem | dec_rot_r_cy_mem;

    // rotate network; all shapes are wired every cycle and the decode picks
    // one, which costs a few muxes but keeps the path to the flops flat
    // left through carry
    assign rot_l_cy = {mem_rdata_in[TOP-STEP:LSB], carry};
    assign rot_r = {mem_rdata_in[LSB], mem_rdata_in[TOP:LSB+STEP]};
    assign rot_r_cy = {carry, mem_rdata_in[TOP:LSB+STEP]};

    // borrow arithmetic unit
    // it sees the live working register and carry, so back to back ops
    // chain through state with no bypass path
    rsd_subtractor #(
        .WIDTH(WIDTH)
    ) u_sub (
        .minuend_in(working_reg),
        .subtrahend_in(mem_rdata_in),
        .carry_in(carry),
        .diff_out(sub_diff),
        .flags_out(sub_flags)
    );

    // memory-side result; only the two memory-target ops use it, and
    // otherwise the held write data is offered so nothing toggles
    always_comb begin
        mem_result = mem_wr_data;
        if (dec_rot_r_mem) begin
            mem_result = rot_r;
        end else if (dec_rot_r_cy_mem) begin
            mem_result = rot_r_cy;
        end
    end

    // working register; memory-target ops and idle cycles leave it alone
    // no enable bit: the default of the if chain is simply to hold
    always_ff @(posedge ref_clk_in) begin
        if (!rst_n_in) begin
            working_reg <= WIDTH'(WREG_RESET);
        end else if (dec_rot_l_cy_wreg) begin
            working_reg <= rot_l_cy;
        end else if (dec_rot_r_wreg) begin
            working_reg <= rot_r;
        end else if (dec_rot_r_cy_wreg) begin
            working_reg <= rot_r_cy;
        end else if (dec_sub_borrow) begin
            working_reg <= sub_diff;
        end
    end

    // carry flag; the only flag that the carry rotates may touch, and the
    // plain rotates must not, since code tests carry across them
    always_ff @(posedge ref_clk_in) begin
        if (!rst_n_in) begin
            carry <= FLAG_RESET;
        end else if (carry_from_msb) begin
            carry <= mem_rdata_in[TOP];
        end else if (carry_from_lsb) begin
            carry <= mem_rdata_in[LSB];
        end else if (dec_sub_borrow) begin
            carry <= sub_flags.carry;
        end
    end

    // zero, half-borrow and range flags change only on subtraction;
    // every rotate keeps them, so a test of zero may follow a rotate
    // without being disturbed by it
    always_ff @(posedge ref_clk_in) begin
        if (!rst_n_in) begin
            zero <= FLAG_RESET;
            half_borrow_flag <= FLAG_RESET;
            twos_compl_range_flag <= FLAG_RESET;
        end else if (dec_sub_borrow) begin
            zero <= sub_flags.zero;
            half_borrow_flag <= sub_flags.half_borrow_flag;
            twos_compl_range_flag <= sub_flags.twos_compl_range_flag;
        end
    end

    // write strobe: one-cycle pulse per memory-target op; memory sees it a
    // cycle after the op, so an op on the same byte right behind it still
    // reads the old value and the decoder has to allow for that
    always_ff @(posedge ref_clk_in) begin
        if (!rst_n_in) begin
            mem_wr_strobe <= 1'b0;
        end else begin
            mem_wr_strobe <= writes_mem;
        end
    end

    // write data: held between writes so a slow memory may latch it late
    // at the price of one extra register bank
    always_ff @(posedge ref_clk_in) begin
        if (!rst_n_in) begin
            mem_wr_data <= '0;
        end else if (writes_mem) begin
            mem_wr_data <= mem_result;
        end
    end

    // outputs come straight from the flops above; structs only regroup them
    assign working_reg_out = working_reg;
    assign flags_out = '{twos_compl_range_flag, zero, half_borrow_flag, carry};
    assign mem_wr_out = '{mem_wr_strobe, mem_wr_data};
endmodule
`default_nettype wire

// File: sim/rsd_props.sv
// assertions for the rotate and subtract datapath
// sees only the top ports; each result lands one edge after its op
`timescale 1ns/1ps
`default_nettype none
module rsd_props
    import rsd_pkg::*;
#(parameter int WIDTH = DATA_W) (
    input wire logic ref_clk_in,
    input wire logic rst_n_in,
    input wire op_e op_in,
    input wire logic [WIDTH-1:0] mem_rdata_in,
    input wire logic [WIDTH-1:0] working_reg_out,
    input wire flags_s flags_out,
    input wire mem_wr_s mem_wr_out
);
    // short aliases; d is the 9-bit difference, bit 8 set on borrow
    wire logic [7:0] m = mem_rdata_in;
    wire logic [7:0] w = working_reg_out;
    wire logic c = flags_out.carry;
    wire logic [8:0] d = {1'b0, w} - {1'b0, m} - {8'h00, ~c};
    // low nibble difference for the half flag, signed difference for range
    wire logic [4:0] h = {1'b0, w[3:0]} - {1'b0, m[3:0]} - {4'h0, ~c};
    wire logic signed [9:0] sd = $signed({w[7], w[7], w}) - $signed({m[7], m[7], m})
        - $signed({9'h000, ~c});
    wire logic ovf = (sd > 10'sd127) || (sd < -10'sd128);
    default clocking @(posedge ref_clk_in); endclocking
    default disable iff (!rst_n_in);
    rl_cy_a: assert property (
        op_in == OP_ROT_L_CY_WREG |=> w == {$past(m[6:0]), $past(c)} && c == $past(m[7]))
        else $error("rotate left mismatch");
    rr_mem_a: assert property (
        op_in == OP_ROT_R_MEM |=> mem_wr_out == {1'b1, $past(m[0]), $past(m[7:1])}
        && $stable(flags_out)) else $error("rotate memory mismatch");
    rr_wreg_a: assert property (
        op_in == OP_ROT_R_WREG |=> w == {$past(m[0]), $past(m[7:1])} && $stable(flags_out))
        else $error("rotate to wreg mismatch");
    rrc_mem_a: assert property (
        op_in == OP_ROT_R_CY_MEM |=> mem_wr_out == {1'b1, $past(c), $past(m[7:1])}
        && c == $past(m[0]) && $stable(flags_out[3:1]))
        else $error("carry rotate memory mismatch");
    rrc_wreg_a: assert property (
        op_in == OP_ROT_R_CY_WREG |=> w == {$past(c), $past(m[7:1])} && c == $past(m[0]))
        else $error("carry rotate wreg mismatch");
    sub_diff_a: assert property (
        op_in == OP_SUB_BORROW |=> w == $past(d[7:0])) else $error("difference mismatch");
    sub_flags_a: assert property (
        op_in == OP_SUB_BORROW |=> c == !$past(d[8]) && flags_out.zero == (w == 8'h00))
        else $error("subtract flags mismatch");
    sub_half_a: assert property (
        op_in == OP_SUB_BORROW |=> flags_out.half_borrow_flag == !$past(h[4]))
        else $error("half borrow flag mismatch");
    sub_range_a: assert property (
        op_in == OP_SUB_BORROW |=> flags_out.twos_compl_range_flag == $past(ovf))
        else $error("range flag mismatch");
    mem_keep_a: assert property (
        op_in != OP_ROT_R_MEM && op_in != OP_ROT_R_CY_MEM |=> !mem_wr_out.wr)
        else $error("memory write without memory op");
    cover property (op_in == OP_SUB_BORROW && d[8]);
    cover property (op_in == OP_SUB_BORROW ##1 flags_out.twos_compl_range_flag);
    cover property (mem_wr_out.wr);
    cover property (op_in == OP_ROT_R_CY_WREG && c);
endmodule
bind rotate_and_subtract_datapath rsd_props #(.WIDTH(WIDTH)) u_props (.ref_clk_in, .rst_n_in,
    .op_in, .mem_rdata_in, .working_reg_out, .flags_out, .mem_wr_out);
`default_nettype wire

// File: sim/rotate_and_subtract_datapath_tb_top.sv
// self-checking bench for the rotate and subtract datapath
// drives the ports itself; expected values follow from the reset state
`timescale 1ns/1ps
`default_nettype none
module rotate_and_subtract_datapath_tb_top;
    import rsd_pkg::*;
    logic ref_clk_in = 1'b0;
    logic rst_n_in = 1'b0;
    op_e op_in = OP_NONE;
    logic [7:0] mem_rdata_in = 8'h00;
    logic [7:0] working_reg_out;
    flags_s flags_out;
    mem_wr_s mem_wr_out;
    int failures = 0;
    int check_count = 0;
    rotate_and_subtract_datapath u_dut (.ref_clk_in, .rst_n_in, .op_in, .mem_rdata_in,
        .working_reg_out, .flags_out, .mem_wr_out);
    // 40 MHz clock
    initial begin
        forever #12.5 ref_clk_in = ~ref_clk_in;
    end
    // one op for one edge; sample 1 ns after the answering edge so updates have landed
    task automatic run(input op_e o, input logic [7:0] m);
        @(posedge ref_clk_in);
        op_in <= o;
        mem_rdata_in <= m;
        @(posedge ref_clk_in);
        op_in <= OP_NONE;
        #1;
    endtask
    // compares {wr, data, wreg, flags}
    task automatic chk(input logic [20:0] e);
        check_count++;
        if ({mem_wr_out, working_reg_out, flags_out} !== e) begin
            failures++;
            $display("wrong value at %0t: got %h expected %h", $time,
                {mem_wr_out, working_reg_out, flags_out}, e);
        end
    endtask
    task automatic print_verdict();
        $display("checks %0d failures %0d", check_count, failures);
        if (failures == 0 && check_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    // scenario: left rotate through carry from the reset state
    task automatic test_rotate_left();
        // carry starts clear, so bit 0 of wreg must come out clear
        run(OP_ROT_L_CY_WREG, 8'h81);
        chk({1'b0, 8'h00, 8'h02, 4'h1});
        $display("rotate left done");
    endtask
    // scenario: plain right rotates to memory and to wreg
    task automatic test_rotate_right();
        // carry is set here, so a flag wipe would show
        run(OP_ROT_R_MEM, 8'h01);
        chk({1'b1, 8'h80, 8'h02, 4'h1});
        // the write strobe must drop again on the next op
        run(OP_ROT_R_WREG, 8'h02);
        chk({1'b0, 8'h80, 8'h01, 4'h1});
        $display("rotate right done");
    endtask
    // scenario: carry rotates, each using the carry left by the one before
    task automatic test_carry_rotates();
        run(OP_ROT_L_CY_WREG, 8'h40);
        chk({1'b0, 8'h80, 8'h81, 4'h0});
        run(OP_ROT_R_CY_MEM, 8'h03);
        chk({1'b1, 8'h01, 8'h81, 4'h1});
        // result differs from the old wreg so a missed load would show
        run(OP_ROT_R_CY_WREG, 8'h04);
        chk({1'b0, 8'h01, 8'h82, 4'h0});
        $display("carry rotates done");
    endtask
    // scenario: borrow in, zero result, negative result, signed overflow
    task automatic test_subtract();
        run(OP_ROT_R_WREG, 8'h0a);
        chk({1'b0, 8'h01, 8'h05, 4'h0});
        run(OP_SUB_BORROW, 8'h03);
        chk({1'b0, 8'h01, 8'h01, 4'h3});
        run(OP_SUB_BORROW, 8'h01);
        chk({1'b0, 8'h01, 8'h00, 4'h7});
        run(OP_SUB_BORROW, 8'h01);
        chk({1'b0, 8'h01, 8'hff, 4'h0});
        run(OP_ROT_R_WREG, 8'h01);
        chk({1'b0, 8'h01, 8'h80, 4'h0});
        // -128 minus 1 minus the borrow leaves the signed range
        run(OP_SUB_BORROW, 8'h01);
        chk({1'b0, 8'h01, 8'h7e, 4'h9});
        $display("subtract done");
    endtask
    // scenario: reset in mid-run clears all state, then the first op after it
    task automatic test_reset();
        @(posedge ref_clk_in);
        rst_n_in <= 1'b0;
        repeat (2) @(posedge ref_clk_in);
        rst_n_in <= 1'b1;
        #1;
        chk({1'b0, 8'h00, 8'h00, 4'h0});
        // carry must be clear again, so bit 0 comes out clear
        run(OP_ROT_L_CY_WREG, 8'h01);
        chk({1'b0, 8'h00, 8'h02, 4'h0});
        $display("reset done");
    endtask
    initial begin
        repeat (8) @(posedge ref_clk_in);
        rst_n_in <= 1'b1;
        test_rotate_left();
        test_rotate_right();
        test_carry_rotates();
        test_subtract();
        test_reset();
        print_verdict();
    end
endmodule
`default_nettype wire
